/* verilog/smc_static_memory_ctrl.sv */
// Operation
// RULE_01: Idle gap of idle_gap_count+1 before turnaround accesses
// RULE_02: Reads last read_wait_count+3 cycles
// RULE_03: Read lane selects high unless enable set
// RULE_04: Writes: setup, write_wait_count+1 strobe, hold
// RULE_05: Burst ROM subsequent reads last write_wait_count+1
// RULE_06: Write wait field resets to all ones
// RULE_07: Oversize request sets sticky oversize flag
// RULE_08: Protected write sets flag; one clears it
// RULE_09: Software writes zeros to reserved bits
// RULE_10: Write-protect bit protects its bank
// RULE_11: Burst ROM bit enables subsequent read timing
// RULE_12: Memory width field selects 8/16/32 bits
// RULE_13: Address bits 25:24 pick bank chip select
// RULE_14: Protected writes produce no external strobe
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_static_memory_ctrl
  import smc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             irq_out,
  input  wire logic        sys_req_in,
  input  wire logic        sys_write_in,
  input  wire logic [2:0]  sys_size_in,
  input  wire logic        sys_burst_in,
  input  wire logic [25:0] sys_addr_in,
  input  wire logic [3:0]  sys_lanes_in,
  input  wire logic [31:0] sys_wdata_in,
  output logic             sys_busy_out,
  output logic             sys_ack_out,
  output logic             sys_err_out,
  output logic      [31:0] sys_rdata_out,
  output logic      [23:0] mem_addr_out,
  output logic      [31:0] mem_data_out,
  output logic             mem_data_oe_out,
  input  wire logic [31:0] mem_data_in,
  output logic      [3:0]  cs_n_out,
  output logic      [3:0]  byte_lane_select_n_out,
  output logic             we_n_out,
  output logic             oe_n_out
);

  localparam logic [3:0][31:0] CFG_RST = {`SMC_CFG3_RST, `SMC_CFG2_RST, `SMC_CFG1_RST, `SMC_CFG0_RST};

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Declarations
  smc_state_t  state_ff;
  smc_state_t  nxt_state;
  logic [5:0]  cnt_ff;
  logic [5:0]  nxt_cnt;
  logic [4:0]  idle_cnt_ff;
  logic [31:0] cfg_ff [4];
  logic [1:0]  cur_bank_ff;
  logic        cur_write_ff;
  logic [2:0]  cur_size_ff;
  logic        cur_burst_ff;
  logic [23:0] cur_addr_ff;
  logic [3:0]  cur_lanes_ff;
  logic [31:0] cur_wdata_ff;
  logic        cur_err_ff;
  logic [1:0]  last_bank_ff;
  logic        last_write_ff;
  logic        last_valid_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;
  logic [3:0]  nxt_cs_n;
  logic [3:0]  nxt_bls_n;

  // ==========================================================
  // Request selection
  wire        in_idle    = (state_ff == SMC_IDLE);
  wire        req_take   = in_idle && sys_req_in;
  wire [1:0]  sel_bank   = in_idle ? sys_addr_in[25:24] : cur_bank_ff;  // [RULE_13]
  wire        sel_write  = in_idle ? sys_write_in : cur_write_ff;
  wire [2:0]  sel_size   = in_idle ? sys_size_in : cur_size_ff;
  wire        sel_burst  = in_idle ? sys_burst_in : cur_burst_ff;
  wire [23:0] sel_addr   = in_idle ? sys_addr_in[23:0] : cur_addr_ff;
  wire [3:0]  sel_lanes  = in_idle ? sys_lanes_in : cur_lanes_ff;
  wire [31:0] sel_wdata  = in_idle ? sys_wdata_in : cur_wdata_ff;
  wire [31:0] cfg_sel    = cfg_ff[sel_bank];

  wire [3:0]  idle_gap   = cfg_sel[`SMC_IDLE_MSB:`SMC_IDLE_LSB];
  wire [4:0]  read_wait  = cfg_sel[`SMC_RWAIT_MSB:`SMC_RWAIT_LSB];
  wire [4:0]  write_wait = cfg_sel[`SMC_WWAIT_MSB:`SMC_WWAIT_LSB];
  wire        rlane_en   = cfg_sel[`SMC_RLANE_BIT];
  wire        width_8    = (smc_width_t'(cfg_sel[`SMC_WIDTH_MSB:`SMC_WIDTH_LSB]) == SMC_W8);
  wire        width_16   = (smc_width_t'(cfg_sel[`SMC_WIDTH_MSB:`SMC_WIDTH_LSB]) == SMC_W16);
  wire [3:0]  width_mask = width_8 ? 4'h1 : (width_16 ? 4'h3 : 4'hf);  // [RULE_12]

  wire        oversize   = (sel_size > `SMC_SIZE_WORD);  // [RULE_07]
  wire        protect    = sel_write && cfg_sel[`SMC_WP_BIT];  // [RULE_10]
  wire        reject     = oversize || protect;
  wire        ovr_evt    = req_take && oversize;  // [RULE_07]
  wire        prot_evt   = req_take && !oversize && protect;  // [RULE_08]

  wire        burst_sub  = !sel_write && cfg_sel[`SMC_BURST_BIT] && sel_burst && last_valid_ff
                           && (last_bank_ff == sel_bank) && !last_write_ff;  // [RULE_11]
  wire        need_gap   = last_valid_ff && ((last_bank_ff != sel_bank) || (last_write_ff != sel_write));
  wire        gap_ok     = !need_gap || (idle_cnt_ff >= {1'b0, idle_gap});  // [RULE_01]
  wire [5:0]  read_len_m1 = burst_sub ? {1'b0, write_wait}
                                      : ({1'b0, read_wait} + `SMC_READ_EXTRA);  // [RULE_02] [RULE_05]
  wire        start_read = !sel_write;
  wire        acc_state  = (state_ff == SMC_READ) || (state_ff == SMC_SETUP)
                           || (state_ff == SMC_STROBE) || (state_ff == SMC_HOLD);
  wire        acc_begin  = ((nxt_state == SMC_READ) || (nxt_state == SMC_SETUP))
                           && (in_idle || (state_ff == SMC_TURN));

  // ==========================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMC_IDLE: begin
        if (sys_req_in) begin
          if (reject) begin
            nxt_state = SMC_DONE;  // [RULE_14]
          end else if (gap_ok) begin
            nxt_state = start_read ? SMC_READ : SMC_SETUP;
          end else begin
            nxt_state = SMC_TURN;
          end
        end
      end
      SMC_TURN: begin
        if (gap_ok) begin
          nxt_state = start_read ? SMC_READ : SMC_SETUP;  // [RULE_01]
        end
      end
      SMC_READ: begin
        if (cnt_ff == 6'h00) begin
          nxt_state = SMC_DONE;
        end
      end
      SMC_SETUP:  nxt_state = SMC_STROBE;  // [RULE_04]
      SMC_STROBE: begin
        if (cnt_ff == 6'h00) begin
          nxt_state = SMC_HOLD;
        end
      end
      SMC_HOLD:   nxt_state = SMC_DONE;
      SMC_DONE:   nxt_state = SMC_IDLE;
      default:    nxt_state = SMC_IDLE;
    endcase
  end

  always_comb begin
    if ((nxt_state == SMC_READ) && (state_ff != SMC_READ)) begin
      nxt_cnt = read_len_m1;  // [RULE_02]
    end else if ((nxt_state == SMC_STROBE) && (state_ff != SMC_STROBE)) begin
      nxt_cnt = {1'b0, write_wait};  // [RULE_04]
    end else if (cnt_ff != 6'h00) begin
      nxt_cnt = cnt_ff - 6'h01;
    end else begin
      nxt_cnt = 6'h00;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff    <= SMC_IDLE;
      cnt_ff      <= 6'h00;
      idle_cnt_ff <= `SMC_IDLE_SAT;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      if (acc_state) begin
        idle_cnt_ff <= 5'h00;
      end else if (idle_cnt_ff != `SMC_IDLE_SAT) begin
        idle_cnt_ff <= idle_cnt_ff + 5'h01;  // [RULE_01]
      end
    end
  end

  // ==========================================================
  // Request capture and access history
  always_ff @(posedge clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cur_bank_ff   <= 2'h0;
      cur_write_ff  <= 1'b0;
      cur_size_ff   <= 3'h0;
      cur_burst_ff  <= 1'b0;
      cur_addr_ff   <= 24'h000000;
      cur_lanes_ff  <= 4'h0;
      cur_wdata_ff  <= 32'h00000000;
      cur_err_ff    <= 1'b0;
      last_bank_ff  <= 2'h0;
      last_write_ff <= 1'b0;
      last_valid_ff <= 1'b0;
    end else begin
      if (req_take) begin
        cur_bank_ff  <= sel_bank;
        cur_write_ff <= sel_write;
        cur_size_ff  <= sel_size;
        cur_burst_ff <= sel_burst;
        cur_addr_ff  <= sel_addr;
        cur_lanes_ff <= sel_lanes;
        cur_wdata_ff <= sel_wdata;
        cur_err_ff   <= reject;
      end
      if (acc_begin) begin
        last_bank_ff  <= sel_bank;
        last_write_ff <= sel_write;
        last_valid_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // External pins
  wire nxt_cs_act  = (nxt_state == SMC_READ) || (nxt_state == SMC_STROBE) || (nxt_state == SMC_HOLD);
  wire nxt_drive   = (nxt_state == SMC_SETUP) || (nxt_state == SMC_STROBE) || (nxt_state == SMC_HOLD);
  wire nxt_rd_end  = (state_ff == SMC_READ) && (cnt_ff == 6'h00);

  always_comb begin
    if (nxt_state == SMC_READ) begin
      nxt_bls_n = rlane_en ? 4'h0 : 4'hf;  // [RULE_03]
    end else if (nxt_state == SMC_STROBE) begin
      nxt_bls_n = ~(sel_lanes & width_mask);  // [RULE_04] [RULE_12]
    end else begin
      nxt_bls_n = 4'hf;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      wire        bank_hit = (sel_bank == 2'(b));
      wire        wr_hit   = reg_wr_in && (reg_addr_in == (`SMC_OFS_CFG0 + 8'(4 * b)));
      wire [31:0] rw_part  = wr_hit ? (reg_wdata_in & `SMC_CFG_RW_MASK) : (cfg_ff[b] & `SMC_CFG_RW_MASK);
      wire        ovr_nxt  = (ovr_evt && bank_hit)
                             || (cfg_ff[b][`SMC_OVR_BIT] && !(wr_hit && reg_wdata_in[`SMC_OVR_BIT]));  // [RULE_07]
      wire        prot_nxt = (prot_evt && bank_hit)
                             || (cfg_ff[b][`SMC_PROT_BIT] && !(wr_hit && reg_wdata_in[`SMC_PROT_BIT]));  // [RULE_08]

      assign nxt_cs_n[b] = !(nxt_cs_act && bank_hit);  // [RULE_13]

      always_ff @(posedge clk_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
          cfg_ff[b] <= CFG_RST[b];  // [RULE_06]
        end else begin
          cfg_ff[b] <= rw_part | ({31'h0, ovr_nxt} << `SMC_OVR_BIT) | ({31'h0, prot_nxt} << `SMC_PROT_BIT);  // [RULE_09]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cs_n_out               <= 4'hf;
      byte_lane_select_n_out <= 4'hf;
      we_n_out               <= 1'b1;
      oe_n_out               <= 1'b1;
      mem_addr_out           <= 24'h000000;
      mem_data_out           <= 32'h00000000;
      mem_data_oe_out        <= 1'b0;
      sys_busy_out           <= 1'b0;
      sys_ack_out            <= 1'b0;
      sys_err_out            <= 1'b0;
      sys_rdata_out          <= 32'h00000000;
    end else begin
      cs_n_out               <= nxt_cs_n;
      byte_lane_select_n_out <= nxt_bls_n;
      we_n_out               <= (nxt_state != SMC_STROBE);  // [RULE_04] [RULE_14]
      oe_n_out               <= (nxt_state != SMC_READ);
      mem_addr_out           <= sel_addr;
      mem_data_out           <= sel_wdata;
      mem_data_oe_out        <= nxt_drive;
      sys_busy_out           <= (nxt_state != SMC_IDLE);
      sys_ack_out            <= (nxt_state == SMC_DONE);
      sys_err_out            <= (nxt_state == SMC_DONE) && (in_idle ? reject : cur_err_ff);
      if (nxt_rd_end) begin
        sys_rdata_out <= mem_data_in;
      end
    end
  end

  // ==========================================================
  // Interrupt status, mask and register reads
  wire        stat_hit  = reg_wr_in && (reg_addr_in == `SMC_OFS_IRQ_STAT);
  wire        mask_hit  = reg_wr_in && (reg_addr_in == `SMC_OFS_IRQ_MASK);
  wire [1:0]  stat_clr  = stat_hit ? reg_wdata_in[1:0] : 2'h0;
  wire [1:0]  nxt_stat  = {prot_evt, ovr_evt} | (irq_stat_ff & ~stat_clr);
  wire [31:0] rd_mux    = (reg_addr_in == `SMC_OFS_CFG0)     ? cfg_ff[0] :
                          (reg_addr_in == `SMC_OFS_CFG1)     ? cfg_ff[1] :
                          (reg_addr_in == `SMC_OFS_CFG2)     ? cfg_ff[2] :
                          (reg_addr_in == `SMC_OFS_CFG3)     ? cfg_ff[3] :
                          (reg_addr_in == `SMC_OFS_IRQ_STAT) ? {30'h0, irq_stat_ff} :
                          (reg_addr_in == `SMC_OFS_IRQ_MASK) ? {30'h0, irq_mask_ff} : 32'h00000000;

  always_ff @(posedge clk_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      irq_stat_ff   <= 2'h0;
      irq_mask_ff   <= 2'h0;
      irq_out       <= 1'b0;
      reg_rdata_out <= 32'h00000000;
    end else begin
      irq_stat_ff   <= nxt_stat;
      if (mask_hit) begin
        irq_mask_ff <= reg_wdata_in[1:0];
      end
      irq_out       <= |(nxt_stat & irq_mask_ff);
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

endmodule

/* include/smc_map.svh */
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ==========================================================
// Register offsets (byte offsets from the block base)
`define SMC_REG_BASE      32'hffe00000
`define SMC_OFS_CFG0      8'h00
`define SMC_OFS_CFG1      8'h04
`define SMC_OFS_CFG2      8'h08
`define SMC_OFS_CFG3      8'h0c
`define SMC_OFS_IRQ_STAT  8'h10
`define SMC_OFS_IRQ_MASK  8'h14

// ==========================================================
// Bank configuration fields
`define SMC_IDLE_MSB      3
`define SMC_IDLE_LSB      0
`define SMC_RWAIT_MSB     9
`define SMC_RWAIT_LSB     5
`define SMC_RLANE_BIT     10
`define SMC_WWAIT_MSB     15
`define SMC_WWAIT_LSB     11
`define SMC_OVR_BIT       24
`define SMC_PROT_BIT      25
`define SMC_WP_BIT        26
`define SMC_BURST_BIT     27
`define SMC_WIDTH_MSB     29
`define SMC_WIDTH_LSB     28
`define SMC_CFG_RW_MASK   32'h3c00ffef

// ==========================================================
// Reset values
`define SMC_CFG0_RST      32'h2000fbef
`define SMC_CFG1_RST      32'h2000fbef
`define SMC_CFG2_RST      32'h1000fbef
`define SMC_CFG3_RST      32'h0000fbef

// ==========================================================
// Access sizes and timing offsets
`define SMC_SIZE_WORD     3'h2
`define SMC_READ_EXTRA    6'h02
`define SMC_IDLE_SAT      5'h1f

`endif

/* include/smc_pkg.sv */
package smc_pkg;

  // ==========================================================
  // Access sequencer states, Gray from IDLE through DONE on the write path
  typedef enum logic [2:0] {
    SMC_IDLE   = 3'b000,
    SMC_TURN   = 3'b001,
    SMC_READ   = 3'b011,
    SMC_SETUP  = 3'b010,
    SMC_STROBE = 3'b110,
    SMC_HOLD   = 3'b111,
    SMC_DONE   = 3'b101
  } smc_state_t;

  // ==========================================================
  // Bank data width encoding
  typedef enum logic [1:0] {
    SMC_W8  = 2'b00,
    SMC_W16 = 2'b01,
    SMC_W32 = 2'b10,
    SMC_WRS = 2'b11
  } smc_width_t;

endpackage

/* tb/smc_static_memory_ctrl_assertions.sv */
`timescale 1ns/1ps

module smc_static_memory_ctrl_assertions (
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       sys_req_in,
  input wire logic [2:0] sys_size_in,
  input wire logic       sys_busy_out,
  input wire logic       sys_ack_out,
  input wire logic       sys_err_out,
  input wire logic       mem_data_oe_out,
  input wire logic [3:0] cs_n_out,
  input wire logic [3:0] byte_lane_select_n_out,
  input wire logic       we_n_out,
  input wire logic       oe_n_out
);
  // ==========================================================
  // Helpers
  wire take = sys_req_in && !sys_busy_out;
  wire big  = take && (sys_size_in > 3'h2);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================================
  // Properties
  property p_one_cs; $countones(~cs_n_out) <= 1; endproperty
  a_one_cs: assert property (p_one_cs) else $error("two chip selects low");
  property p_we_cs; !we_n_out |-> cs_n_out != 4'hf; endproperty
  a_we_cs: assert property (p_we_cs) else $error("write strobe without chip select");
  property p_rd_lanes; !oe_n_out |-> byte_lane_select_n_out inside {4'hf, 4'h0}; endproperty
  a_rd_lanes: assert property (p_rd_lanes) else $error("mixed lanes in read");
  property p_hold; $rose(we_n_out) |-> cs_n_out != 4'hf ##1 (cs_n_out == 4'hf && sys_ack_out); endproperty
  a_hold: assert property (p_hold) else $error("write hold cycle wrong");
  property p_setup; $fell(we_n_out) |-> $past(cs_n_out) == 4'hf && $past(mem_data_oe_out); endproperty
  a_setup: assert property (p_setup) else $error("write setup cycle missing");
  property p_big_err; big |-> ##[1:3] (sys_ack_out && sys_err_out); endproperty
  a_big_err: assert property (p_big_err) else $error("oversize not rejected");
  property p_big_quiet; big |=> (cs_n_out == 4'hf) [*3]; endproperty
  a_big_quiet: assert property (p_big_quiet) else $error("oversize moved pins");
  property p_err_ack; sys_err_out |-> sys_ack_out && we_n_out && $past(cs_n_out) == 4'hf; endproperty
  a_err_ack: assert property (p_err_ack) else $error("reject moved pins or lacked ack");
  property p_ack_pulse; sys_ack_out |=> !sys_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_busy; take |=> sys_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised");
endmodule

bind smc_static_memory_ctrl smc_static_memory_ctrl_assertions u_smc_static_memory_ctrl_assertions (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .sys_req_in(sys_req_in), .sys_size_in(sys_size_in),
  .sys_busy_out(sys_busy_out), .sys_ack_out(sys_ack_out), .sys_err_out(sys_err_out),
  .mem_data_oe_out(mem_data_oe_out), .cs_n_out(cs_n_out),
  .byte_lane_select_n_out(byte_lane_select_n_out), .we_n_out(we_n_out), .oe_n_out(oe_n_out));

/* tb/smc_mem_model.sv */
`timescale 1ns/1ps

module smc_mem_model (
  input  wire logic        clk_in,
  input  wire logic [23:0] mem_addr_in,
  input  wire logic [31:0] mem_data_in,
  input  wire logic [3:0]  cs_n_in,
  input  wire logic [3:0]  lane_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  output logic      [31:0] mem_data_out
);
  // ==========================================================
  // Small word store, bank ignored
  logic [31:0] mem [16];
  logic [31:0] last;
  wire         sel = cs_n_in != 4'hf;
  wire         drv = sel && !oe_n_in;
  wire [3:0]   idx = mem_addr_in[3:0];

  initial begin
    last = 32'h0;
    for (int i = 0; i < 16; i++) mem[i] = 32'h0;
  end

  always @(posedge clk_in) begin
    if (drv) last <= mem[idx];
    for (int k = 0; k < 4; k++)
      if (sel && !we_n_in && !lane_n_in[k]) mem[idx][8*k+:8] <= mem_data_in[8*k+:8];
  end

  // Released bus shows inverse of last value
  assign mem_data_out = drv ? mem[idx] : ~last;
endmodule

/* tb/test_static_memory_bank_timing.sv */
`timescale 1ns/1ps
`include "smc_map.svh"

module test_static_memory_bank_timing
  import smc_pkg::*;
;
  logic        clk_in, arst_n_in, reg_wr_in, reg_rd_in, irq_out;
  logic        sys_req_in, sys_write_in, sys_burst_in, sys_busy_out, sys_ack_out, sys_err_out;
  logic        mem_data_oe_out, we_n_out, oe_n_out, err_seen;
  logic [7:0]  reg_addr_in;
  logic [2:0]  sys_size_in;
  logic [25:0] sys_addr_in;
  logic [23:0] mem_addr_out, addr_wr;
  logic [3:0]  sys_lanes_in, cs_n_out, byte_lane_select_n_out, bls_rd, bls_wr, cs_rd;
  logic [31:0] reg_wdata_in, reg_rdata_out, sys_wdata_in, sys_rdata_out, mem_data_out, mem_data_in;
  int          error_cnt, total_checks, idle_cnt, gap_seen, oe_len, we_len;

  smc_static_memory_ctrl u_smc_static_memory_ctrl (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .sys_req_in(sys_req_in), .sys_write_in(sys_write_in),
    .sys_size_in(sys_size_in), .sys_burst_in(sys_burst_in), .sys_addr_in(sys_addr_in),
    .sys_lanes_in(sys_lanes_in), .sys_wdata_in(sys_wdata_in), .sys_busy_out(sys_busy_out),
    .sys_ack_out(sys_ack_out), .sys_err_out(sys_err_out), .sys_rdata_out(sys_rdata_out),
    .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out),
    .mem_data_in(mem_data_in), .cs_n_out(cs_n_out), .byte_lane_select_n_out(byte_lane_select_n_out),
    .we_n_out(we_n_out), .oe_n_out(oe_n_out));

  smc_mem_model u_smc_mem_model (.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_data_in(mem_data_out),
    .cs_n_in(cs_n_out), .lane_n_in(byte_lane_select_n_out), .we_n_in(we_n_out), .oe_n_in(oe_n_out),
    .mem_data_out(mem_data_in));

  // ==========================================================
  // Clock and pin monitor
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (cs_n_out == 4'hf) idle_cnt <= idle_cnt + 1;
    else begin
      if (idle_cnt != 0) gap_seen <= idle_cnt;
      idle_cnt <= 0;
    end
    if (!oe_n_out) begin
      oe_len <= oe_len + 1;
      bls_rd <= byte_lane_select_n_out;
      cs_rd <= cs_n_out;
    end
    if (!we_n_out) begin
      we_len <= we_len + 1;
      bls_wr <= byte_lane_select_n_out;
      addr_wr <= mem_addr_out;
    end
  end

  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] cfg(input logic [1:0] w, input logic bm, input logic wp, input logic [4:0] ww,
                                      input logic rl, input logic [4:0] rw, input logic [3:0] id);
    return {2'h0, w, bm, wp, 10'h000, ww, rl, rw, 1'b0, id};
  endfunction

  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(posedge clk_in);
    chk(nm, e & m, reg_rdata_out & m);
  endtask

  task automatic sys(input logic [1:0] b, input logic w, input logic [2:0] sz, input logic bu, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    oe_len <= 0;
    we_len <= 0;
    sys_req_in <= 1'b1;
    sys_write_in <= w;
    sys_size_in <= sz;
    sys_burst_in <= bu;
    sys_addr_in <= {b, 24'h000010};
    sys_wdata_in <= d;
    @(posedge clk_in);
    sys_req_in <= 1'b0;
    while (sys_ack_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 300) chk("ack", 1, 0);
    err_seen = sys_err_out;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    logic [31:0] rst [4];
    rst = '{`SMC_CFG0_RST, `SMC_CFG1_RST, `SMC_CFG2_RST, `SMC_CFG3_RST};
    for (int i = 0; i < 4; i++) reg_rd(8'(4 * i), 32'hff00ffef, rst[i], "cfg_reset");
    reg_rd(`SMC_OFS_IRQ_STAT, 32'hffffffff, 32'h0, "stat_reset");
  endtask

  task automatic test_write_gap;
    reg_wr(`SMC_OFS_CFG0, cfg(2'h2, 0, 0, 5'h01, 0, 5'h00, 4'h7));
    sys(0, 1, 3'h2, 0, 32'h1234abcd);
    chk("we_len", 2, we_len);
    chk("bls_wr", 4'h0, bls_wr);
    chk("addr_wr", 32'h00000010, addr_wr);
    sys(0, 0, 3'h2, 0, 0);
    chk("gap", 1, gap_seen >= 8);
    chk("rdata", 32'h1234abcd, sys_rdata_out);
    chk("rd_len0", 3, oe_len);
  endtask

  task automatic test_read_lanes;
    reg_wr(`SMC_OFS_CFG1, cfg(2'h2, 0, 0, 5'h00, 0, 5'h02, 4'h0));
    sys(1, 0, 3'h2, 0, 0);
    chk("rd_len1", 5, oe_len);
    chk("bls_rd_hi", 4'hf, bls_rd);
    chk("cs_rd", 4'hd, cs_rd);
    chk("rdata1", 32'h1234abcd, sys_rdata_out);
    reg_wr(`SMC_OFS_CFG1, cfg(2'h1, 0, 0, 5'h00, 1, 5'h02, 4'h0));
    sys(1, 0, 3'h2, 0, 0);
    chk("bls_rd_lo", 4'h0, bls_rd);
    sys(1, 1, 3'h2, 0, 32'h5555aaaa);
    chk("w16_lanes", 4'hc, bls_wr);
  endtask

  task automatic test_burst;
    reg_wr(`SMC_OFS_CFG2, cfg(2'h2, 1, 0, 5'h00, 0, 5'h04, 4'h0));
    sys(2, 0, 3'h2, 0, 0);
    chk("rd_len2", 7, oe_len);
    sys(2, 0, 3'h2, 1, 0);
    chk("burst_len", 1, oe_len);
  endtask

  task automatic test_protect;
    reg_wr(`SMC_OFS_IRQ_MASK, 32'h2);
    reg_wr(`SMC_OFS_CFG3, cfg(2'h0, 0, 1, 5'h00, 0, 5'h00, 4'h0));
    sys(3, 1, 3'h2, 0, 32'hffffffff);
    chk("wp_err", 1, err_seen);
    chk("wp_we", 0, we_len);
    reg_rd(`SMC_OFS_CFG3, 32'h06000000, 32'h06000000, "wp_flag");
    reg_rd(`SMC_OFS_IRQ_STAT, 32'hffffffff, 32'h2, "stat_wp");
    chk("irq_wp", 1, irq_out);
    reg_wr(`SMC_OFS_IRQ_STAT, 32'h2);
    reg_wr(`SMC_OFS_CFG3, 32'h02000000);
    reg_rd(`SMC_OFS_CFG3, 32'h06000000, 32'h0, "wp_clear");
    chk("irq_clr", 0, irq_out);
    sys(3, 1, 3'h2, 0, 32'hffffffff);
    chk("w8_err", 0, err_seen);
    chk("w8_lanes", 4'he, bls_wr);
    chk("w8_len", 1, we_len);
  endtask

  task automatic test_oversize;
    sys(0, 0, 3'h3, 0, 0);
    chk("ovr_err", 1, err_seen);
    chk("ovr_pins", 0, oe_len);
    reg_rd(`SMC_OFS_IRQ_STAT, 32'hffffffff, 32'h1, "stat_ovr");
    chk("irq_mask", 0, irq_out);
    reg_wr(`SMC_OFS_IRQ_MASK, 32'h3);
    reg_rd(`SMC_OFS_IRQ_MASK, 32'hffffffff, 32'h3, "mask");
    chk("irq_ovr", 1, irq_out);
    reg_wr(`SMC_OFS_IRQ_STAT, 32'h1);
    reg_rd(`SMC_OFS_IRQ_STAT, 32'hffffffff, 32'h0, "stat_clr");
    chk("irq_off", 0, irq_out);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {arst_n_in, reg_wr_in, reg_rd_in, sys_req_in, sys_write_in, sys_burst_in} = '0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    sys_size_in = 3'h2;
    sys_addr_in = 26'h0;
    sys_lanes_in = 4'hf;
    sys_wdata_in = 32'h0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    test_reset();
    test_write_gap();
    test_read_lanes();
    test_burst();
    test_protect();
    test_oversize();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    summarize();
  end
endmodule
